//--- inc/ssp_pkg.sv
// Constants and types shared by the synchronous serial port design
package ssp_pkg;
  // ----------------------------------------
  // Data path and framing
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FRAME_MIN = 4;
  localparam int FRAME_MAX = 16;
  localparam int CTRL_BITS = 8;
  localparam int REPLY_GAP = 1;
  // ----------------------------------------
  // Bit rate
  // ----------------------------------------
  localparam int PRESCALE_MIN = 2;
  localparam int PRESCALE_MAX = 254;
  localparam int RATE_MAX = 256;
  // ----------------------------------------
  // Service levels and timeout
  // ----------------------------------------
  localparam int TX_SVC_LEVEL = 4;
  localparam int RX_SVC_LEVEL = 4;
  localparam int TIMEOUT_BIT_PERIODS = 32;
  localparam int TIMEOUT_HALVES = 2 * TIMEOUT_BIT_PERIODS;
  // ----------------------------------------
  // Interrupt source positions and reset values
  // ----------------------------------------
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_OVERRUN = 3;
  localparam int IRQ_N = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {FMT_PULSED, FMT_SPI, FMT_CTRL} format_t;
  typedef enum logic {ST_IDLE, ST_RUN} state_t;
endpackage

//--- src/ssp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign count = wr_ptr_reg - rd_ptr_reg;
  assign in_ready = count != (AW + 1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  // ----------------------------------------
  // Storage, one write enable per entry
  // ----------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock) begin
      if (push && wr_ptr_reg[AW-1:0] == AW'(i)) begin
        mem[i] <= in_data;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  fifo_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    push && !pop |=> count == $past(count) + 1'b1)
    else $error("FIFO count did not grow on push");
endmodule

//--- src/sync_serial_port.sv
// Synchronous serial port master: bit clock, framing, FIFOs, interrupts
`timescale 1ns/1ps
module sync_serial_port
  import ssp_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_HALVES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire format_t frame_format,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic loopback,
  input wire logic [3:0] frame_size_m1,
  input wire logic [7:0] clock_prescale_divisor,
  input wire logic [7:0] serial_clock_rate,
  input wire logic fifo_data_write,
  input wire logic [15:0] fifo_data_in,
  output logic fifo_data_write_ready,
  input wire logic fifo_data_read,
  output logic [15:0] fifo_data_out,
  output logic fifo_data_out_valid,
  input wire logic [3:0] interrupt_mask_register,
  input wire logic overrun_clear,
  output logic [3:0] raw_interrupt_state,
  output logic [3:0] masked_interrupt_state,
  output logic interrupt_request,
  output logic busy,
  output logic serial_clock_pin,
  output logic frame_select_pin,
  output logic serial_tx_pin,
  output logic serial_tx_oe_n,
  input wire logic serial_rx_pin
);
  localparam int TW = $clog2(TIMEOUT_LIMIT + 1);

  if (TIMEOUT_LIMIT < 1) begin : g_bad_timeout
    $error("TIMEOUT_LIMIT must be at least 1");
  end

  // ----------------------------------------
  // Registers and FIFO wiring
  // ----------------------------------------
  state_t state_reg;
  logic [6:0] pre_cnt_reg;
  logic [7:0] rate_cnt_reg;
  logic [5:0] h_reg;
  logic [15:0] sh_reg;
  logic [15:0] rx_sh_reg;
  logic sck_reg;
  logic fs_reg;
  logic tx_out_reg;
  logic oe_n_reg;
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic overrun_reg;
  logic [TW-1:0] idle_cnt_reg;
  logic [3:0] raw_reg;
  logic [3:0] masked_reg;
  logic irq_reg;
  logic [15:0] tx_word;
  logic tx_valid;
  logic [3:0] tx_count;
  logic [3:0] rx_count;
  logic rx_ready;

  // ----------------------------------------
  // Bit rate divider
  // ----------------------------------------
  // Half the even prescale value makes one prescale count; serial_clock_rate + 1 counts give one serial clock edge
  wire [6:0] pre_half = (clock_prescale_divisor[7:1] == 7'h00) ? 7'h01
                        : clock_prescale_divisor[7:1];
  wire pre_tick = enable && (pre_cnt_reg >= pre_half - 7'h01);
  wire half_tick = pre_tick && (rate_cnt_reg >= serial_clock_rate);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 7'h00;
      rate_cnt_reg <= 8'h00;
    end else if (!enable || pre_tick) begin
      pre_cnt_reg <= 7'h00;
      rate_cnt_reg <= (!enable || half_tick) ? 8'h00 : rate_cnt_reg + 8'h01;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  wire is_ti = frame_format == FMT_PULSED;
  wire is_spi = frame_format == FMT_SPI;
  wire is_ctrl = frame_format == FMT_CTRL;
  wire [3:0] fsz = (frame_size_m1 < 4'(FRAME_MIN - 1)) ? 4'(FRAME_MIN - 1) : frame_size_m1;
  wire [4:0] nbits = 5'(fsz) + 5'h01;
  wire [4:0] reply_at = 5'(CTRL_BITS + REPLY_GAP);
  wire [4:0] slots = is_ctrl ? nbits + reply_at : nbits;
  wire [1:0] d0 = is_ti ? 2'h2 : ((is_spi && clock_phase_bit) ? 2'h1 : 2'h0);
  wire [5:0] last_edge = {slots, 1'b0};
  wire [5:0] end_h = last_edge + ((d0 == 2'h0) ? 6'h01 : 6'h02);
  wire [5:0] rel = h_reg - 6'(d0);
  wire [4:0] slot = rel[5:1];
  wire in_data = (h_reg >= 6'(d0)) && (slot < slots);
  wire do_drive = in_data && !rel[0];
  wire do_sample = in_data && rel[0] && (!is_ctrl || slot >= reply_at);
  wire do_toggle = is_ti ? (h_reg <= last_edge + 6'h01)
                   : (h_reg != 6'h00 && h_reg <= last_edge);
  wire at_end = h_reg == end_h;
  wire idle_lvl = is_spi && clock_polarity_bit;
  wire rx_in = loopback ? tx_out_reg : rx_s2_reg;

  // ----------------------------------------
  // Sequencing strobes
  // ----------------------------------------
  wire start = state_reg == ST_IDLE && half_tick && tx_valid;
  wire step = state_reg == ST_RUN && half_tick;
  wire finish = step && at_end;
  wire cont = is_spi && clock_phase_bit && tx_valid;
  wire tx_pop = start || (finish && cont);
  wire rx_push = finish;
  wire act = start || step;
  // Command words sit in the low byte; data is aligned to bit 15
  wire [15:0] load_word = is_ctrl ? {tx_word[7:0], 8'h00}
                          : tx_word << (5'h10 - nbits);
  wire [15:0] sh_src = start ? load_word : sh_reg;

  // ----------------------------------------
  // Frame state machine
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      h_reg <= 6'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          h_reg <= 6'h00;
          if (start) begin
            state_reg <= ST_RUN;
            h_reg <= 6'h01;
          end
        end
        ST_RUN: begin
          if (!enable) begin
            state_reg <= ST_IDLE;
            h_reg <= 6'h00;
          end else if (finish && cont) begin
            h_reg <= 6'h01;
          end else if (finish) begin
            state_reg <= ST_IDLE;
            h_reg <= 6'h00;
          end else if (step) begin
            h_reg <= h_reg + 6'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          h_reg <= 6'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Shifters and pins
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= 16'h0000;
      rx_sh_reg <= 16'h0000;
      tx_out_reg <= 1'b0;
    end else begin
      if (act && do_drive) begin
        tx_out_reg <= sh_src[15];
        sh_reg <= {sh_src[14:0], 1'b0};
      end else if (tx_pop) begin
        sh_reg <= load_word;
      end else if (state_reg == ST_IDLE) begin
        tx_out_reg <= 1'b0;
      end
      if (start || (finish && cont)) begin
        rx_sh_reg <= 16'h0000;
      end else if (step && do_sample) begin
        rx_sh_reg <= {rx_sh_reg[14:0], rx_in};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg <= 1'b0;
      fs_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && !start) begin
      sck_reg <= idle_lvl;
      fs_reg <= !is_ti;
      oe_n_reg <= is_ti;
    end else if (start) begin
      sck_reg <= is_ti ? 1'b1 : idle_lvl;
      fs_reg <= is_ti;
      oe_n_reg <= 1'b0;
    end else if (step) begin
      if (do_toggle) begin
        sck_reg <= ~sck_reg;
      end
      if (is_ti && h_reg == 6'h02) begin
        fs_reg <= 1'b0;
      end else if (finish && !cont) begin
        fs_reg <= !is_ti;
      end
    end
  end

  // Only the second stage is read; the first may be metastable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
    end else begin
      rx_s1_reg <= serial_rx_pin;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(fifo_data_write),
    .in_ready(fifo_data_write_ready),
    .in_data(fifo_data_in),
    .out_valid(tx_valid),
    .out_ready(tx_pop),
    .out_data(tx_word),
    .count(tx_count)
  );

  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(rx_push),
    .in_ready(rx_ready),
    .in_data(rx_sh_reg),
    .out_valid(fifo_data_out_valid),
    .out_ready(fifo_data_read),
    .out_data(fifo_data_out),
    .count(rx_count)
  );

  // ----------------------------------------
  // Interrupt sources
  // ----------------------------------------
  wire timeout_hit = idle_cnt_reg == TW'(TIMEOUT_LIMIT);
  wire [3:0] raw_next = {overrun_reg, timeout_hit,
                         rx_count >= 4'(RX_SVC_LEVEL),
                         tx_count <= 4'(TX_SVC_LEVEL)};
  wire [3:0] masked_next = raw_next & interrupt_mask_register;

  // Timeout counts idle half bit periods; any read or frame restarts it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_reg <= '0;
    end else if (state_reg != ST_IDLE || start || fifo_data_read || !fifo_data_out_valid) begin
      idle_cnt_reg <= '0;
    end else if (half_tick && !timeout_hit) begin
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
  end

  // Set wins over clear so an overrun in the clearing cycle survives
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (rx_push && !rx_ready) begin
      overrun_reg <= 1'b1;
    end else if (overrun_clear) begin
      overrun_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      raw_reg <= IRQ_RESET;
      masked_reg <= IRQ_RESET;
      irq_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      masked_reg <= masked_next;
      irq_reg <= |masked_next;
    end
  end

  assign raw_interrupt_state = raw_reg;
  assign masked_interrupt_state = masked_reg;
  assign interrupt_request = irq_reg;
  assign busy = state_reg == ST_RUN;
  assign serial_clock_pin = sck_reg;
  assign frame_select_pin = fs_reg;
  assign serial_tx_pin = tx_out_reg;
  assign serial_tx_oe_n = oe_n_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] gap_reg;
  logic gap_ok_reg;
  logic [15:0] cfg_reg;
  wire [15:0] gap_want = 16'(pre_half) * (16'(serial_clock_rate) + 16'h0001);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 16'h0000;
      gap_ok_reg <= 1'b0;
      cfg_reg <= 16'h0000;
    end else begin
      cfg_reg <= {clock_prescale_divisor, serial_clock_rate};
      gap_reg <= half_tick ? 16'h0000 : gap_reg + 16'h0001;
      if (!enable || cfg_reg != {clock_prescale_divisor, serial_clock_rate}) begin
        gap_ok_reg <= 1'b0;
      end else if (half_tick) begin
        gap_ok_reg <= 1'b1;
      end
    end
  end

  bit_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
    half_tick && gap_ok_reg && cfg_reg == {clock_prescale_divisor, serial_clock_rate}
    |-> gap_reg == gap_want - 16'h0001)
    else $error("Serial clock edge spacing wrong");
  idle_clock_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_IDLE && $past(state_reg == ST_IDLE) && $stable(idle_lvl)
    |-> serial_clock_pin == idle_lvl)
    else $error("Serial clock not at idle level");
  spi_select_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_RUN && !is_ti && $stable(frame_format) |-> !frame_select_pin)
    else $error("Frame select released inside frame");
  pulse_select_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_RUN && is_ti && $stable(frame_format)
    |-> frame_select_pin == (h_reg <= 6'h02))
    else $error("Pulsed frame select wrong width");
  pulse_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_IDLE && $past(state_reg == ST_IDLE) && $past(is_ti) && is_ti
    |-> serial_tx_oe_n && !serial_clock_pin && !frame_select_pin)
    else $error("Pulsed format idle pins wrong");
  overrun_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    rx_push && !rx_ready |=> overrun_reg ##1 raw_interrupt_state[IRQ_OVERRUN])
    else $error("Overrun not flagged");
  masked_state_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 masked_interrupt_state == (raw_interrupt_state & $past(interrupt_mask_register)))
    else $error("Masked state does not follow mask");
  irq_or_a: assert property (@(posedge clock) disable iff (!rst_n)
    interrupt_request == |masked_interrupt_state)
    else $error("Interrupt request not OR of masked sources");
  phase1_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    finish && cont && enable |=> busy && !frame_select_pin)
    else $error("Select released between phase 1 words");
  timeout_a: assert property (@(posedge clock) disable iff (!rst_n)
    timeout_hit |-> fifo_data_out_valid && state_reg == ST_IDLE)
    else $error("Timeout without waiting receive data");

  pulsed_frame_c: cover property (@(posedge clock) disable iff (!rst_n)
    finish && is_ti);
  ctrl_frame_c: cover property (@(posedge clock) disable iff (!rst_n)
    finish && is_ctrl);
  phase1_burst_c: cover property (@(posedge clock) disable iff (!rst_n)
    finish && cont);
  overrun_c: cover property (@(posedge clock) disable iff (!rst_n)
    rx_push && !rx_ready);
endmodule

//--- verif/spi_slave_model.sv
// Behavioural far-side serial slave: SPI polarity 0 phase 0, and control format
`timescale 1ns/1ps
module spi_slave_model
  import ssp_pkg::*;
(
  input wire logic serial_clock_pin,
  input wire logic frame_select_pin,
  input wire logic serial_tx_pin,
  input wire logic [15:0] reply_word,
  input wire logic [4:0] bits,
  input wire logic ctrl_mode,
  output logic serial_rx_pin,
  output logic [15:0] captured
);
  // Slave only: the far-master clock limit never arises here
  int idx;
  int falls;
  initial begin
    serial_rx_pin = 1'b0;
    captured = 16'h0000;
    idx = 0;
    falls = 0;
  end
  // Select low opens the frame; in SPI the reply MSB goes out at once
  always @(negedge frame_select_pin) begin
    idx = bits - 1;
    falls = 0;
    serial_rx_pin = ctrl_mode ? 1'b0 : reply_word[idx];
    captured = 16'h0000;
  end
  always @(posedge serial_clock_pin) begin
    if (!frame_select_pin) begin
      captured = {captured[14:0], serial_tx_pin};
    end
  end
  // Control replies start one clock after the last command bit
  always @(negedge serial_clock_pin) begin
    if (!frame_select_pin) begin
      falls = falls + 1;
      if (ctrl_mode && falls == CTRL_BITS + REPLY_GAP) begin
        serial_rx_pin = reply_word[idx];
      end else if ((!ctrl_mode || falls > CTRL_BITS + REPLY_GAP) && idx > 0) begin
        idx = idx - 1;
        serial_rx_pin = reply_word[idx];
      end
    end
  end
  // Released line flips so a stale bit can never look like data
  always @(posedge frame_select_pin) begin
    serial_rx_pin = ~serial_rx_pin;
  end
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module tb_top;
  import ssp_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  format_t frame_format = FMT_SPI;
  logic clock_polarity_bit = 1'b0;
  logic clock_phase_bit = 1'b0;
  logic loopback = 1'b0;
  logic [3:0] frame_size_m1 = 4'h7;
  logic [7:0] clock_prescale_divisor = 8'h04;
  logic [7:0] serial_clock_rate = 8'h02;
  logic fifo_data_write = 1'b0;
  logic [15:0] fifo_data_in = 16'h0000;
  logic fifo_data_read = 1'b0;
  logic [3:0] interrupt_mask_register = 4'h0;
  logic overrun_clear = 1'b0;
  logic [15:0] reply_word = 16'h003C;
  logic fifo_data_write_ready, fifo_data_out_valid, interrupt_request, busy;
  logic serial_clock_pin, frame_select_pin, serial_tx_pin, serial_tx_oe_n, serial_rx_pin;
  logic [15:0] fifo_data_out, captured;
  logic [3:0] raw_interrupt_state, masked_interrupt_state;
  logic [15:0] clk_edges, sel_rises, sel_bad, sel_hi_max, rise_gap;
  int miscompares = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  sync_serial_port #(.TIMEOUT_LIMIT(4)) sync_serial_port_inst (
    .clock(clock), .rst_n(rst_n), .enable(enable), .frame_format(frame_format),
    .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
    .loopback(loopback), .frame_size_m1(frame_size_m1),
    .clock_prescale_divisor(clock_prescale_divisor), .serial_clock_rate(serial_clock_rate),
    .fifo_data_write(fifo_data_write), .fifo_data_in(fifo_data_in),
    .fifo_data_write_ready(fifo_data_write_ready), .fifo_data_read(fifo_data_read),
    .fifo_data_out(fifo_data_out), .fifo_data_out_valid(fifo_data_out_valid),
    .interrupt_mask_register(interrupt_mask_register), .overrun_clear(overrun_clear),
    .raw_interrupt_state(raw_interrupt_state), .masked_interrupt_state(masked_interrupt_state),
    .interrupt_request(interrupt_request), .busy(busy), .serial_clock_pin(serial_clock_pin),
    .frame_select_pin(frame_select_pin), .serial_tx_pin(serial_tx_pin),
    .serial_tx_oe_n(serial_tx_oe_n), .serial_rx_pin(serial_rx_pin));
  spi_slave_model spi_slave_model_inst (
    .serial_clock_pin(serial_clock_pin), .frame_select_pin(frame_select_pin),
    .serial_tx_pin(serial_tx_pin), .reply_word(reply_word),
    .bits({1'b0, frame_size_m1} + 5'h01), .ctrl_mode(frame_format == FMT_CTRL),
    .serial_rx_pin(serial_rx_pin), .captured(captured));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report;
    begin
      if (miscompares == 0 && tests_run > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task automatic check_bit(input string what, input logic seen, input logic exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        miscompares++;
        $display("wrong value %s expected %b seen %b", what, exp, seen);
      end
    end
  endtask
  task automatic check_word(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        miscompares++;
        $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task automatic write_words(input int n, input logic [15:0] first, input logic [15:0] step);
    int i;
    begin
      for (i = 0; i < n; i++) begin
        fifo_data_write = 1'b1;
        fifo_data_in = first + step * 16'(i);
        @(negedge clock);
      end
      fifo_data_write = 1'b0;
      @(negedge clock);
    end
  endtask
  task automatic read_word(input logic [15:0] exp);
    begin
      check_bit("read valid", fifo_data_out_valid, 1'b1);
      check_word("read data", fifo_data_out, exp);
      fifo_data_read = 1'b1;
      @(negedge clock);
      fifo_data_read = 1'b0;
      @(negedge clock);
    end
  endtask
  // Watches the pins until the port has been idle for 40 cycles
  task automatic wait_quiet;
    int quiet, n;
    logic sck_old, sel_old;
    logic [15:0] since, hi_run;
    begin
      quiet = 0;
      n = 0;
      {clk_edges, sel_rises, sel_bad, sel_hi_max, rise_gap, since, hi_run} = '0;
      sck_old = serial_clock_pin;
      sel_old = frame_select_pin;
      while (quiet < 40) begin
        @(negedge clock);
        since++;
        if (serial_clock_pin !== sck_old) begin
          clk_edges++;
          if (frame_select_pin === 1'b1 && frame_format !== FMT_PULSED) sel_bad++;
          if (serial_clock_pin === 1'b1) begin
            rise_gap = since;
            since = 16'h0000;
          end
        end
        if (frame_select_pin === 1'b1 && sel_old !== 1'b1) sel_rises++;
        hi_run = (frame_select_pin === 1'b1) ? hi_run + 16'h0001 : 16'h0000;
        if (hi_run > sel_hi_max) sel_hi_max = hi_run;
        sck_old = serial_clock_pin;
        sel_old = frame_select_pin;
        quiet = (busy === 1'b0) ? quiet + 1 : 0;
        n++;
        if (n > 5000) begin
          miscompares++;
          final_report;
        end
      end
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_idle;
    begin
      check_bit("idle clock", serial_clock_pin, 1'b0);
      check_bit("idle select", frame_select_pin, 1'b1);
      check_bit("busy idle", busy, 1'b0);
      check_word("raw state", {12'h000, raw_interrupt_state}, 16'h0001);
      interrupt_mask_register = 4'h2;
      repeat (2) @(negedge clock);
      check_bit("request masked", interrupt_request, 1'b0);
      interrupt_mask_register = 4'h1;
      repeat (2) @(negedge clock);
      check_bit("request open", interrupt_request, 1'b1);
      check_word("masked state", {12'h000, masked_interrupt_state}, 16'h0001);
    end
  endtask
  // Odd divisor 5 acts as 4; rate 2 gives a 12-cycle bit clock, far below half the system clock
  task automatic test_spi_partner;
    begin
      clock_prescale_divisor = 8'h05;
      enable = 1'b1;
      write_words(1, 16'h00A5, 16'h0000);
      wait_quiet;
      check_word("bit period", rise_gap, 16'h000C);
      check_word("clock edges", clk_edges, 16'h0010);
      check_word("select high in frame", sel_bad, 16'h0000);
      check_word("slave captured", captured, 16'h00A5);
      read_word(16'h003C);
    end
  endtask
  task automatic test_fifo_overrun;
    int i;
    begin
      enable = 1'b0;
      loopback = 1'b1;
      frame_size_m1 = 4'hF;
      clock_prescale_divisor = 8'h02;
      serial_clock_rate = 8'h00;
      interrupt_mask_register = 4'h8;
      write_words(8, 16'hA500, 16'h0101);
      check_bit("write ready full", fifo_data_write_ready, 1'b0);
      check_bit("tx service off", raw_interrupt_state[IRQ_TX], 1'b0);
      write_words(1, 16'h1234, 16'h0000);
      enable = 1'b1;
      wait_quiet;
      check_bit("rx service", raw_interrupt_state[IRQ_RX], 1'b1);
      write_words(1, 16'hFFFF, 16'h0000);
      wait_quiet;
      check_bit("overrun raw", raw_interrupt_state[IRQ_OVERRUN], 1'b1);
      check_bit("overrun request", interrupt_request, 1'b1);
      overrun_clear = 1'b1;
      @(negedge clock);
      overrun_clear = 1'b0;
      repeat (2) @(negedge clock);
      check_bit("overrun cleared", raw_interrupt_state[IRQ_OVERRUN], 1'b0);
      for (i = 0; i < 8; i++) read_word(16'hA500 + 16'h0101 * 16'(i));
      check_bit("rx empty", fifo_data_out_valid, 1'b0);
    end
  endtask
  task automatic test_pulsed;
    begin
      frame_format = FMT_PULSED;
      frame_size_m1 = 4'h3;
      serial_clock_rate = 8'h01;
      repeat (3) @(negedge clock);
      check_bit("pulsed tx released", serial_tx_oe_n, 1'b1);
      check_bit("pulsed clock low", serial_clock_pin, 1'b0);
      check_bit("pulsed select low", frame_select_pin, 1'b0);
      write_words(1, 16'h0009, 16'h0000);
      wait_quiet;
      check_word("select pulse", sel_hi_max, 16'h0004);
      check_word("pulsed period", rise_gap, 16'h0004);
      check_bit("timeout raw", raw_interrupt_state[IRQ_TIMEOUT], 1'b1);
      read_word(16'h0009);
      check_bit("timeout cleared", raw_interrupt_state[IRQ_TIMEOUT], 1'b0);
    end
  endtask
  task automatic test_back_to_back;
    int ph;
    begin
      frame_format = FMT_SPI;
      frame_size_m1 = 4'h7;
      serial_clock_rate = 8'h00;
      for (ph = 0; ph < 2; ph++) begin
        clock_phase_bit = ph[0];
        clock_polarity_bit = ph[0];
        repeat (3) @(negedge clock);
        check_bit("idle polarity", serial_clock_pin, ph[0]);
        write_words(2, 16'h0081, 16'h0101);
        wait_quiet;
        check_word("select rises", sel_rises, (ph == 0) ? 16'h0002 : 16'h0001);
        read_word(16'h0081);
        read_word(16'h0082);
      end
    end
  endtask
  // Control format: command from the low byte, a gap slot, then a 4-bit reply
  task automatic test_control;
    begin
      frame_format = FMT_CTRL;
      loopback = 1'b0;
      frame_size_m1 = 4'h3;
      clock_prescale_divisor = 8'h04;
      serial_clock_rate = 8'h02;
      reply_word = 16'h000A;
      repeat (3) @(negedge clock);
      write_words(1, 16'hA5C3, 16'h0000);
      wait_quiet;
      check_word("control clock edges", clk_edges, 16'h001A);
      check_word("command captured", captured, 16'h1860);
      check_word("control select high", sel_bad, 16'h0000);
      read_word(16'h000A);
    end
  endtask
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    test_idle;
    test_spi_partner;
    test_fifo_overrun;
    test_pulsed;
    test_back_to_back;
    test_control;
    final_report;
  end
endmodule
